// File: priority_supply_selector.sv
// Prioritized three-input supply selector with Wishbone status/control
`timescale 1ns/10ps

module priority_supply_selector #(
   parameter int VALID_CNT = supply_sel_pkg::VALID_CYCLES,
   parameter int SS_CNT = supply_sel_pkg::SS_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins
   input wire supply_sel_pkg::sense_t sense_i,
   input wire logic enable_i,
   input wire logic shutdown_n_i,
   input wire logic output_low_i,
   output logic [2:0] gate_drive_o,
   output logic soft_start_o,
   output logic [2:0] chan_good_n_o,
   output logic chain_o,
   output logic comp_enable_o
);
   import supply_sel_pkg::*;

   // Highest-priority set bit, CH_NONE when empty
   function automatic logic [1:0] pick_first(input logic [2:0] v);
      if (v[0]) begin
         return 2'h0;
      end else if (v[1]) begin
         return 2'h1;
      end else if (v[2]) begin
         return 2'h2;
      end
      return CH_NONE;
   endfunction : pick_first

   // One-hot of a channel index, zero for CH_NONE
   function automatic logic [2:0] onehot(input logic [1:0] c);
      return (c == CH_NONE) ? 3'h0 : 3'(3'h1 << c);
   endfunction : onehot

   // ---------------------------------------------------------------
   // Qualification
   // ---------------------------------------------------------------
   logic [TMR_W-1:0] vtmr_q [NCH];
   logic [TMR_W-1:0] vtmr_d [NCH];
   logic [2:0] good_q, good_d;
   logic [DROP_W-1:0] drop_q, drop_d;
   logic dropped_q, dropped_d;
   logic [2:0] in_win;
   logic [2:0] inhibit_q, inhibit_d;

   // Raw window result; comparators are off in shutdown
   assign in_win = shutdown_n_i ? (~sense_i.high_limit_sense & sense_i.low_limit_sense) : 3'h0;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   seq_t st_q, st_d;
   logic [1:0] cur_q, cur_d;
   logic [2:0] gate_q, gate_d;
   logic [2:0] offl_q, offl_d;
   logic [2:0] revl_q, revl_d;
   logic [2:0] eligible;
   logic [1:0] target;
   logic run;

   logic ss_arm_q, ss_arm_d;
   logic ss_on_q, ss_on_d;
   logic [TMR_W-1:0] ss_tmr_q, ss_tmr_d;
   logic shutdown_n_q;
   logic chain_q, chain_d;

   // Validation timers and connected-channel dropout filter
   always_comb begin
      good_d = good_q;
      drop_d = drop_q;
      dropped_d = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         vtmr_d[i] = vtmr_q[i];
         if (!shutdown_n_i || !in_win[i]) begin
            vtmr_d[i] = '0;
            good_d[i] = 1'b0;
         end else if (vtmr_q[i] >= TMR_W'(VALID_CNT - 1)) begin
            good_d[i] = 1'b1;
         end else begin
            vtmr_d[i] = vtmr_q[i] + 1'b1;
         end
      end
      // The filter only watches the switched-on channel, so the load stays on during
      // a brief excursion and comes off when the channel returns and must revalidate
      if (st_q != ST_ON || in_win[cur_q]) begin
         drop_d = '0;
      end else if (drop_q >= DROP_W'(DROP_CYCLES - 1)) begin
         dropped_d = 1'b1;
      end else begin
         drop_d = drop_q + 1'b1;
      end
   end

   // Connected channel stays eligible while its dropout filter runs
   always_comb begin
      eligible = good_q;
      if (st_q == ST_ON && !dropped_q && shutdown_n_i && !in_win[cur_q]) begin
         eligible = eligible | onehot(cur_q);
      end
      if (dropped_q) begin
         eligible = eligible & ~onehot(cur_q);
      end
      eligible = eligible & ~inhibit_q;
   end

   assign run = enable_i && shutdown_n_i;
   assign target = run ? pick_first(eligible) : CH_NONE;

   // Break-before-make sequencer and soft-start
   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      gate_d = gate_q;
      offl_d = offl_q;
      revl_d = revl_q;
      ss_arm_d = ss_arm_q;
      ss_on_d = ss_on_q;
      ss_tmr_d = ss_tmr_q;
      // Gate-off latch catches the detector only while undriven
      offl_d = offl_d | (sense_i.gate_off_detect & ~gate_q);
      if (ss_on_q) begin
         if (ss_tmr_q >= TMR_W'(SS_CNT - 1)) begin
            ss_on_d = 1'b0;
         end else begin
            ss_tmr_d = ss_tmr_q + 1'b1;
         end
      end
      case (st_q)
         ST_IDLE: begin
            if (target != CH_NONE) begin
               cur_d = target;
               st_d = ST_MAKE;
            end
         end
         ST_MAKE: begin
            if (target != cur_q) begin
               revl_d = revl_d & ~onehot(cur_q);
               cur_d = CH_NONE;
               st_d = ST_IDLE;
            end else if (revl_q[cur_q] || sense_i.reverse_guard[cur_q]) begin
               revl_d = revl_d | onehot(cur_q);
               gate_d = onehot(cur_q);
               offl_d = offl_d & ~onehot(cur_q);
               st_d = ST_ON;
               if (ss_arm_q) begin
                  ss_arm_d = 1'b0;
                  ss_on_d = 1'b1;
                  ss_tmr_d = '0;
               end
            end
         end
         ST_ON: begin
            if (target != cur_q) begin
               gate_d = 3'h0;
               revl_d = revl_d & ~onehot(cur_q);
               ss_on_d = 1'b0;
               st_d = ST_BREAK;
            end
         end
         ST_BREAK: begin
            if (offl_q[cur_q]) begin
               cur_d = CH_NONE;
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
            cur_d = CH_NONE;
            gate_d = 3'h0;
         end
      endcase
      // Re-arm after the case so an event in the cycle of a connection wins
      if ((shutdown_n_i && !shutdown_n_q) || output_low_i) begin
         ss_arm_d = 1'b1;
      end
   end

   // Cascade output; holds its level in the in-between cases
   always_comb begin
      chain_d = chain_q;
      if (!shutdown_n_i) begin
         chain_d = 1'b1;
      end else if (!enable_i || (good_q != 3'h0)) begin
         chain_d = 1'b0;
      end else if (st_q == ST_IDLE && gate_q == 3'h0 && (&offl_q)) begin
         chain_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NCH; i++) begin
            vtmr_q[i] <= '0;
         end
         good_q <= 3'h0;
         drop_q <= '0;
         dropped_q <= 1'b0;
         st_q <= ST_IDLE;
         cur_q <= CH_NONE;
         gate_q <= 3'h0;
         offl_q <= 3'h7;
         revl_q <= 3'h0;
         ss_arm_q <= 1'b1;
         ss_on_q <= 1'b0;
         ss_tmr_q <= '0;
         shutdown_n_q <= 1'b1;
         chain_q <= 1'b1;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            vtmr_q[i] <= vtmr_d[i];
         end
         good_q <= good_d;
         drop_q <= drop_d;
         dropped_q <= dropped_d;
         st_q <= st_d;
         cur_q <= cur_d;
         gate_q <= gate_d;
         offl_q <= offl_d;
         revl_q <= revl_d;
         ss_arm_q <= ss_arm_d;
         ss_on_q <= ss_on_d;
         ss_tmr_q <= ss_tmr_d;
         shutdown_n_q <= shutdown_n_i;
         chain_q <= chain_d;
      end
   end

   assign gate_drive_o = gate_q;
   assign soft_start_o = ss_on_q;
   assign chan_good_n_o = ~good_q;
   assign chain_o = chain_q;
   assign comp_enable_o = shutdown_n_i;

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic req;

   assign req = wb_cyc_i && wb_stb_i && !ack_q;

   // One wait state: ack one cycle after the request; unmapped reads zero
   always_comb begin
      ack_d = req;
      rdat_d = rdat_q;
      inhibit_d = inhibit_q;
      if (req && wb_we_i && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
         inhibit_d = wb_dat_i[2:0];
      end
      if (req && !wb_we_i) begin
         rdat_d = 32'h0;
         case (wb_adr_i)
            CTRL_OFS: begin
               rdat_d[2:0] = inhibit_q;
            end
            STAT_OFS: begin
               rdat_d[STAT_GOOD_LSB +: 3] = good_q;
               rdat_d[STAT_GATE_LSB +: 3] = gate_q;
               rdat_d[STAT_CUR_LSB +: 2] = cur_q;
               rdat_d[STAT_FSM_LSB +: 2] = st_q;
               rdat_d[STAT_SS_BIT] = ss_on_q;
               rdat_d[STAT_CHAIN_BIT] = chain_q;
            end
            default: begin
               rdat_d = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
         inhibit_q <= INHIBIT_RST;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         inhibit_q <= inhibit_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

endmodule : priority_supply_selector

// File: supply_sel_pkg.sv
// Constants, types and register map for the prioritized supply selector
package supply_sel_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_KHZ = 125000;
   localparam int VALID_TIME_MS = 256;
   localparam int DROP_TIME_US = 8;
   localparam int SS_TIME_MS = 32;
   localparam int VALID_CYCLES = VALID_TIME_MS * CLK_KHZ;
   localparam int DROP_CYCLES = (DROP_TIME_US * CLK_KHZ) / 1000;
   localparam int SS_CYCLES = SS_TIME_MS * CLK_KHZ;
   localparam int TMR_W = 25;
   localparam int DROP_W = 11;

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   localparam int NCH = 3;
   localparam logic [1:0] CH_NONE = 2'h3;

   // ---------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [2:0] INHIBIT_RST = 3'h0;
   localparam int STAT_GOOD_LSB = 0;
   localparam int STAT_GATE_LSB = 4;
   localparam int STAT_CUR_LSB = 8;
   localparam int STAT_FSM_LSB = 12;
   localparam int STAT_SS_BIT = 16;
   localparam int STAT_CHAIN_BIT = 17;

   // Per-channel analog comparator results, bit i is channel i+1
   typedef struct packed {
      logic [2:0] high_limit_sense; // 1: above high limit
      logic [2:0] low_limit_sense;  // 1: above low limit
      logic [2:0] gate_off_detect;  // 1: gate within 350mV of source
      logic [2:0] reverse_guard;    // 1: output 120mV below input
   } sense_t;

   // Switch sequencer, Gray coded along idle-make-on-break
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MAKE = 2'b01,
      ST_ON = 2'b11,
      ST_BREAK = 2'b10
   } seq_t;

endpackage : supply_sel_pkg

// File: supply_sel_monitor.sv
// Port-level checker for the supply selector
`timescale 1ns/10ps
module supply_sel_monitor
   import supply_sel_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire supply_sel_pkg::sense_t sense_i,
   input wire logic enable_i,
   input wire logic shutdown_n_i,
   input wire logic [2:0] gate_drive_o,
   input wire logic soft_start_o,
   input wire logic [2:0] chan_good_n_o,
   input wire logic chain_o,
   input wire logic comp_enable_o
);
   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic win1;
   // Raw window of channel one, before any filtering
   assign win1 = sense_i.low_limit_sense[0] & ~sense_i.high_limit_sense[0];
   property p_one; $onehot0(gate_drive_o); endproperty
   a_one: assert property (p_one) else $error("two gates on");
   property p_nosw; gate_drive_o != 3'h0 |=> gate_drive_o == 3'h0 || $stable(gate_drive_o); endproperty
   a_nosw: assert property (p_nosw) else $error("make before break");
   property p_rev; gate_drive_o != 3'h0 && $past(gate_drive_o) == 3'h0 |-> $past(sense_i.reverse_guard) != 3'h0;
   endproperty
   a_rev: assert property (p_rev) else $error("gate on without margin");
   property p_en; (!enable_i) [*4] |-> gate_drive_o == 3'h0; endproperty
   a_en: assert property (p_en) else $error("gate on while disabled");
   property p_shutdown_n; (!shutdown_n_i) [*3] |-> gate_drive_o == 3'h0 && chan_good_n_o == 3'h7; endproperty
   a_shutdown_n: assert property (p_shutdown_n) else $error("active in shutdown");
   property p_comp; comp_enable_o == shutdown_n_i; endproperty
   a_comp: assert property (p_comp) else $error("comparator enable wrong");
   property p_drop; (!win1) [*3] |-> chan_good_n_o[0]; endproperty
   a_drop: assert property (p_drop) else $error("good held out of window");
   property p_pre; gate_drive_o[2] && !chan_good_n_o[0] |-> ##[1:4] !gate_drive_o[2]; endproperty
   a_pre: assert property (p_pre) else $error("no preemption");
   property p_chain; (!enable_i && shutdown_n_i) [*3] |-> !chain_o; endproperty
   a_chain: assert property (p_chain) else $error("chain high while disabled");
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("late ack");
   // Main scenarios seen
   c_pre: cover property (gate_drive_o == 3'h4 ##[1:20] gate_drive_o == 3'h1);
   c_ss: cover property ($rose(soft_start_o));
   c_shutdown_n: cover property ($rose(shutdown_n_i) ##[1:200] soft_start_o);
endmodule : supply_sel_monitor

bind priority_supply_selector supply_sel_monitor i_mon (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .sense_i(sense_i),
   .enable_i(enable_i),
   .shutdown_n_i(shutdown_n_i),
   .gate_drive_o(gate_drive_o),
   .soft_start_o(soft_start_o),
   .chan_good_n_o(chan_good_n_o),
   .chain_o(chain_o),
   .comp_enable_o(comp_enable_o)
);

// File: supply_partner.sv
// Model of the external switch pairs and supply comparators
`timescale 1ns/10ps
module supply_partner
   import supply_sel_pkg::*;
(
   input wire logic clk_i,
   input wire logic [2:0] gate_drive_i,
   input wire logic [2:0] lo_i,
   input wire logic [2:0] hi_i,
   input wire logic slow_i,
   output supply_sel_pkg::sense_t sense_o
);
   logic [7:0] off_q [3] = '{8'hFF, 8'hFF, 8'hFF};
   logic [7:0] dly;
   logic [2:0] off;
   // Slow mode mimics large gate charge, so the sequencer has to wait
   assign dly = slow_i ? 8'h28 : 8'h02;
   // Gate discharge time per channel; saturates so an idle gate reads off
   always @(posedge clk_i) begin
      for (int i = 0; i < 3; i++) begin
         if (gate_drive_i[i]) begin
            off_q[i] <= 8'h00;
         end else if (off_q[i] != 8'hFF) begin
            off_q[i] <= off_q[i] + 8'h01;
         end
      end
   end
   // Detector true only once the gate has discharged
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         off[i] = off_q[i] >= dly;
      end
   end
   // Output droops below the inputs only after every switch is open
   assign sense_o = '{hi_i, lo_i, off, (&off && gate_drive_i == 3'h0) ? 3'h7 : 3'h0};
endmodule : supply_partner

// File: tb_top.sv
// Self-checking bench for the prioritized supply selector
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("unexpected %s %h %h", nm, e, a); end end
module tb_top;
   import supply_sel_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b1, shn = 1'b1, olow = 1'b0, slow = 1'b0;
   logic ack, ss, chain, comp;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [2:0] lo = 3'h0, hi = 3'h0, gate, good_n;
   sense_t sense;
   int err_total = 0;
   int n_tests = 0;
   // 125 MHz
   always #4 clk_i = ~clk_i;
   priority_supply_selector #(.VALID_CNT(20), .SS_CNT(50)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .sense_i(sense), .enable_i(en), .shutdown_n_i(shn), .output_low_i(olow),
      .gate_drive_o(gate), .soft_start_o(ss), .chan_good_n_o(good_n), .chain_o(chain), .comp_enable_o(comp));
   supply_partner i_far (.clk_i(clk_i), .gate_drive_i(gate), .lo_i(lo), .hi_i(hi), .slow_i(slow), .sense_o(sense));
   // Verdict
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : settle
   // Bounded wait on the gate pattern; a timeout ends the run
   task automatic wait_gate(input logic [2:0] v, input int lim);
      int k;
      k = 0;
      while (gate !== v && k < lim) begin
         settle(1);
         k++;
      end
      `CHK("gate", v, gate)
      if (gate !== v) summarize();
   endtask : wait_gate
   // Classic cycle: held until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20) begin
         err_total++;
         summarize();
      end
   endtask : wb
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      settle(1);
      `CHK("gate", 3'h0, gate)
      `CHK("chain", 1'b1, chain)
      $display("t1 done");
      @(posedge clk_i) lo <= 3'h4;
      settle(15);
      `CHK("good_n", 3'h7, good_n)
      wait_gate(3'h4, 40);
      `CHK("good_n", 3'h3, good_n)
      `CHK("ss", 1'b1, ss)
      `CHK("chain", 1'b0, chain)
      settle(70);
      `CHK("ss", 1'b0, ss)
      $display("t2 done");
      @(posedge clk_i) lo <= 3'h5;
      wait_gate(3'h1, 60);
      `CHK("ss", 1'b0, ss)
      $display("t3 done");
      @(posedge clk_i) hi <= 3'h1;
      settle(500);
      `CHK("gate", 3'h1, gate)
      `CHK("good_n", 3'h3, good_n)
      @(posedge clk_i) hi <= 3'h0;
      settle(15);
      `CHK("good_n", 3'h3, good_n)
      settle(10);
      `CHK("good_n", 3'h2, good_n)
      @(posedge clk_i) hi <= 3'h1;
      settle(900);
      `CHK("gate", 3'h1, gate)
      wait_gate(3'h4, 200);
      $display("t4 done");
      @(posedge clk_i) lo <= 3'h7;
      settle(5);
      @(posedge clk_i) en <= 1'b0;
      settle(25);
      `CHK("gate", 3'h0, gate)
      `CHK("good_n", 3'h1, good_n)
      `CHK("chain", 1'b0, chain)
      @(posedge clk_i) en <= 1'b1;
      wait_gate(3'h2, 12);
      $display("t5 done");
      wb(1'b1, CTRL_OFS, 32'h2);
      wait_gate(3'h4, 20);
      wb(1'b0, STAT_OFS, 32'h0);
      `CHK("status", 32'h0000_3246, q)
      wb(1'b0, CTRL_OFS, 32'h0);
      `CHK("ctrl", 32'h2, q)
      wb(1'b0, 4'h8, 32'h0);
      `CHK("unmapped", 32'h0, q)
      wb(1'b1, CTRL_OFS, 32'h0);
      wait_gate(3'h2, 20);
      $display("t6 done");
      @(posedge clk_i) slow <= 1'b1;
      shn <= 1'b0;
      settle(50);
      `CHK("good_n", 3'h7, good_n)
      `CHK("chain", 1'b1, chain)
      `CHK("comp", 1'b0, comp)
      @(posedge clk_i) shn <= 1'b1;
      settle(15);
      `CHK("good_n", 3'h7, good_n)
      wait_gate(3'h2, 200);
      `CHK("ss", 1'b1, ss)
      @(posedge clk_i) en <= 1'b0;
      settle(3);
      `CHK("ss", 1'b0, ss)
      @(posedge clk_i) olow <= 1'b1;
      @(posedge clk_i) olow <= 1'b0;
      en <= 1'b1;
      settle(20);
      `CHK("gate", 3'h0, gate)
      wait_gate(3'h2, 100);
      `CHK("ss", 1'b1, ss)
      $display("t7 done");
      summarize();
   end
endmodule : tb_top
